// ---- hw/alu_core.sv ----
// accumulator datapath with apb register access
module alu_core
   import alu_pkg::*;
(
   // clock and reset
   input  wire logic              clock,
   input  wire logic              rst_n,
   input  wire logic              ce,
   // apb slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [APB_AW-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   // core state
   output logic                   halted
);
   state_t              state_reg;
   state_t              state_next;
   logic [23:0]         instr_reg;
   logic [7:0]          acc_reg;
   logic [7:0]          acc_next;
   logic                c_reg;
   logic                dc_reg;
   logic                z_reg;
   logic                c_next;
   logic                dc_next;
   logic                z_next;
   logic                to_n_reg;
   logic                pd_n_reg;
   logic [15:0]         ptr0_reg;
   logic [15:0]         ptr1_reg;
   logic [15:0]         ptr0_next;
   logic [15:0]         ptr1_next;
   logic [FILE_AW-1:0]  faddr_reg;
   logic [7:0]          wdog_reg;
   logic [7:0]          wpre_reg;
   logic [7:0]          fdata;
   logic [31:0]         rd_mux;

   // apb decode
   wire access   = psel && penable;
   wire ready_ok = (state_reg == st_idle) || (state_reg == st_sleep);
   wire done     = access && pready;
   wire wr_done  = done && pwrite;
   wire hit_instr  = paddr == ADDR_INSTR;
   wire hit_acc    = paddr == ADDR_ACC;
   wire hit_status = paddr == ADDR_STATUS;
   wire hit_ptr0   = paddr == ADDR_PTR0;
   wire hit_ptr1   = paddr == ADDR_PTR1;
   wire hit_faddr  = paddr == ADDR_FADDR;
   wire hit_fdata  = paddr == ADDR_FDATA;
   wire hit_wdog   = paddr == ADDR_WDOG;
   wire mapped = hit_instr | hit_acc | hit_status | hit_ptr0 | hit_ptr1
      | hit_faddr | hit_fdata | hit_wdog;
   wire ready_next = access && !pready && ready_ok;
   // instructions written while halted are dropped
   wire start = wr_done && hit_instr && (state_reg == st_idle);
   wire wake  = wr_done && hit_status && pwdata[ST_WAKE];

   // instruction fields
   wire op_t              op   = op_t'(instr_reg[OP_MSB:OP_LSB]);
   wire                   dest = instr_reg[DEST_BIT];
   wire                   pidx = instr_reg[PIDX_BIT];
   wire [FILE_AW-1:0]     fa   = instr_reg[FA_MSB:FA_LSB];
   wire [7:0]             lit  = instr_reg[LIT_MSB:LIT_LSB];
   wire exec = (state_reg == st_exec) && ce;

   // operand routing
   wire is_imm = (op == and_imm_into_acc) || (op == add_imm_into_acc)
      || (op == imm_minus_acc);
   wire is_and = (op == and_imm_into_acc) || (op == and_acc_with_file);
   wire is_add = (op == add_imm_into_acc) || (op == add_acc_with_file)
      || (op == add_acc_file_carry);
   wire is_sub = (op == imm_minus_acc) || (op == file_minus_acc)
      || (op == file_minus_acc_borrow);
   wire is_asr = op == arith_shift_right_file;
   wire is_rrf = op == rotate_right_thru_carry;
   wire is_arith = is_add || is_sub;
   wire is_file = is_asr || is_rrf || (op == and_acc_with_file)
      || (op == add_acc_with_file) || (op == add_acc_file_carry)
      || (op == file_minus_acc) || (op == file_minus_acc_borrow);
   wire [7:0] b_opnd = is_imm ? lit : fdata;
   // subtraction is a + ~w + carry-in, so carry out means no borrow
   wire use_c = (op == add_acc_file_carry) || (op == file_minus_acc_borrow);
   wire cin   = use_c ? c_reg : is_sub; // RQ12
   wire [7:0] x_op = is_sub ? b_opnd : acc_reg; // RQ10 RQ11
   wire [7:0] y_op = is_sub ? ~acc_reg : b_opnd;
   wire [8:0] sum9 = {1'b0, x_op} + {1'b0, y_op} + {8'h00, cin}; // RQ4 RQ6 RQ8
   wire [4:0] hsum = {1'b0, x_op[3:0]} + {1'b0, y_op[3:0]} + {4'h0, cin};

   // result select
   wire [7:0] res =
      is_arith ? sum9[7:0] :
      is_and   ? (acc_reg & b_opnd) : // RQ3 RQ5
      is_asr   ? {fdata[7], fdata[7:1]} : // RQ7
      is_rrf   ? {c_reg, fdata[7:1]} : // RQ9
      acc_reg;
   wire c_new  = is_arith ? sum9[8] : (is_asr || is_rrf) ? fdata[0] : c_reg; // RQ14
   wire dc_new = is_arith ? hsum[4] : dc_reg; // RQ14
   wire z_upd  = is_arith || is_and || is_asr;
   wire z_new  = z_upd ? (res == 8'h00) : z_reg; // RQ14
   wire to_acc  = is_imm || (is_file && !dest);
   wire to_file = is_file && dest;

   // pointer arithmetic, natural 16-bit wrap
   wire [15:0] sext    = {{10{lit[5]}}, lit[5:0]}; // RQ1
   wire [15:0] ptr_sel = pidx ? ptr1_reg : ptr0_reg;
   wire [15:0] ptr_sum = ptr_sel + sext; // RQ2
   wire ptr_add = exec && (op == pointer_add_imm);

   // next values
   assign acc_next = (exec && to_acc) ? res
      : (wr_done && hit_acc) ? pwdata[7:0] : acc_reg;
   // flags move on exec or a status write; pointer add leaves them alone
   assign c_next  = exec ? c_new
      : (wr_done && hit_status) ? pwdata[ST_C] : c_reg;
   assign dc_next = exec ? dc_new
      : (wr_done && hit_status) ? pwdata[ST_DC] : dc_reg;
   assign z_next  = exec ? z_new
      : (wr_done && hit_status) ? pwdata[ST_Z] : z_reg;
   assign ptr0_next = (ptr_add && !pidx) ? ptr_sum // RQ1
      : (wr_done && hit_ptr0) ? pwdata[15:0] : ptr0_reg;
   assign ptr1_next = (ptr_add && pidx) ? ptr_sum
      : (wr_done && hit_ptr1) ? pwdata[15:0] : ptr1_reg;

   // memory port: fetch owns the read address for one cycle
   wire [FILE_AW-1:0] raddr = (state_reg == st_fetch) ? fa : faddr_reg;
   wire mem_we = (exec && to_file) || (wr_done && hit_fdata); // RQ5 RQ6
   wire [FILE_AW-1:0] waddr = exec ? fa : faddr_reg;
   wire [7:0] wdata = exec ? res : pwdata[7:0];

   file_mem u_mem (
      .clock (clock),
      .rst_n (rst_n),
      .ce    (ce),
      .we    (mem_we),
      .waddr (waddr),
      .wdata (wdata),
      .raddr (raddr),
      .rdata (fdata)
   );

   wire [7:0] status_rd = {1'b0, (state_reg == st_sleep),
      !ready_ok, to_n_reg, pd_n_reg, z_reg, dc_reg, c_reg};
   assign rd_mux =
      hit_instr  ? {8'h00, instr_reg} :
      hit_acc    ? {24'h0, acc_reg} :
      hit_status ? {24'h0, status_rd} :
      hit_ptr0   ? {16'h0, ptr0_reg} :
      hit_ptr1   ? {16'h0, ptr1_reg} :
      hit_faddr  ? {25'h0, faddr_reg} :
      hit_fdata  ? {24'h0, fdata} :
      hit_wdog   ? {24'h0, wdog_reg} : 32'h0;

   always_comb begin
      case (state_reg)
         st_idle:  state_next = start ? st_fetch : st_idle;
         st_fetch: state_next = st_exec;
         st_exec:  state_next = (op == op_sleep) ? st_sleep : st_idle; // RQ13
         st_sleep: state_next = wake ? st_idle : st_sleep;
         default:  state_next = st_idle;
      endcase
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         state_reg <= st_idle;
         instr_reg <= 24'h000000;
         halted    <= 1'b0;
      end else if (ce) begin
         state_reg <= state_next;
         halted    <= state_next == st_sleep;
         if (start) begin
            instr_reg <= pwdata[23:0];
         end
      end
   end

   // bus answer one cycle into the access phase, held while busy
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0;
      end else if (ce) begin
         pready  <= ready_next;
         pslverr <= ready_next && !mapped;
         prdata  <= ready_next ? rd_mux : 32'h0;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         acc_reg  <= ACC_RST;
         c_reg    <= 1'b0;
         dc_reg   <= 1'b0;
         z_reg    <= 1'b0;
         ptr0_reg <= PTR_RST;
         ptr1_reg <= PTR_RST;
      end else if (ce) begin
         acc_reg  <= acc_next;
         c_reg    <= c_next;
         dc_reg   <= dc_next;
         z_reg    <= z_next;
         ptr0_reg <= ptr0_next;
         ptr1_reg <= ptr1_next;
      end
   end

   // watchdog stops with the oscillator while halted; it only wraps
   wire sleep_go = exec && (op == op_sleep);
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         faddr_reg <= '0;
         to_n_reg  <= TO_N_RST;
         pd_n_reg  <= PD_N_RST;
         wdog_reg  <= 8'h00;
         wpre_reg  <= 8'h00;
      end else if (ce) begin
         if (wr_done && hit_faddr) begin
            faddr_reg <= pwdata[FILE_AW-1:0];
         end
         if (sleep_go) begin
            to_n_reg <= 1'b1; // RQ13
            pd_n_reg <= 1'b0; // RQ13
            wdog_reg <= 8'h00; // RQ13
            wpre_reg <= 8'h00; // RQ13
         end else if (state_reg != st_sleep) begin
            wpre_reg <= (wpre_reg == WDOG_PRE_MAX) ? 8'h00 : wpre_reg + 8'h01;
            if (wpre_reg == WDOG_PRE_MAX) begin
               wdog_reg <= wdog_reg + 8'h01;
            end
         end
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   a_ptr_flags_kept: assert property (ptr_add |=> // RQ1
      c_reg == $past(c_reg) && z_reg == $past(z_reg)
      && dc_reg == $past(dc_reg))
      else $error("pointer add changed a flag");
   a_ptr_wrap_sum: assert property (ptr_add && !pidx |=> // RQ2
      ptr0_reg == $past(ptr_sum))
      else $error("pointer 0 not updated with wrapped sum");
   a_ptr1_wrap_sum: assert property (ptr_add && pidx |=> // RQ2
      ptr1_reg == 16'($past(ptr1_reg)
      + {{10{$past(lit[5])}}, $past(lit[5:0])}))
      else $error("pointer 1 not updated with wrapped sum");
   a_and_imm_acc: assert property (exec && op == and_imm_into_acc |=> // RQ3
      acc_reg == ($past(acc_reg) & $past(lit)) && c_reg == $past(c_reg))
      else $error("and immediate result wrong");
   a_add_imm_carry: assert property (exec && op == add_imm_into_acc |=> // RQ4
      {c_reg, acc_reg} == {1'b0, $past(acc_reg)} + {1'b0, $past(lit)}
      && dc_reg == ($past({1'b0, acc_reg[3:0]} + {1'b0, lit[3:0]})
      > 5'h0f))
      else $error("add immediate flags wrong");
   a_and_file_dest: assert property (exec && op == and_acc_with_file // RQ5
      && dest |-> mem_we && wdata == (acc_reg & fdata))
      else $error("and to file not written back");
   a_add_file_acc: assert property (exec && op == add_acc_with_file // RQ6
      && !dest |=> acc_reg == 8'($past(acc_reg) + $past(fdata))
      && !$past(mem_we))
      else $error("add to accumulator wrong");
   a_asr_shape: assert property (exec && is_asr |-> // RQ7
      res == {fdata[7], fdata[7:1]} && c_new == fdata[0])
      else $error("arithmetic shift wrong");
   a_asr_to_acc: assert property (exec && is_asr && !dest |=> // RQ7
      acc_reg == {$past(fdata[7]), $past(fdata[7:1])}
      && c_reg == $past(fdata[0]))
      else $error("shift result not in accumulator");
   a_addc_sum: assert property (exec && op == add_acc_file_carry |-> // RQ8
      {c_new, res} == {1'b0, acc_reg} + {1'b0, fdata} + {8'h00, c_reg})
      else $error("add with carry wrong");
   a_rrf_only_c: assert property (exec && is_rrf |=> // RQ9
      c_reg == $past(fdata[0]) && z_reg == $past(z_reg))
      else $error("rotate changed more than carry");
   a_imm_minus_acc_carry: assert property (exec && op == imm_minus_acc |=> // RQ10
      c_reg == ($past(acc_reg) <= $past(lit)))
      else $error("literal minus acc carry wrong");
   a_file_minus_acc_dc: assert property (exec && op == file_minus_acc |-> // RQ11
      dc_new == (acc_reg[3:0] <= fdata[3:0]))
      else $error("file minus acc half carry wrong");
   a_file_minus_acc_borrow_val: assert property (exec && op == file_minus_acc_borrow |-> // RQ12
      res == fdata - acc_reg - {7'h00, !c_reg})
      else $error("subtract with borrow wrong");
   a_file_minus_acc_borrow_carry: assert property (exec && op == file_minus_acc_borrow |-> // RQ12
      c_new == ({1'b0, fdata} >= {1'b0, acc_reg} + {8'h00, !c_reg}))
      else $error("subtract with borrow carry wrong");
   a_sleep_entry: assert property (sleep_go |=> // RQ13
      wdog_reg == 8'h00 && to_n_reg && !pd_n_reg && halted
      && state_reg == st_sleep)
      else $error("sleep entry incomplete");
   a_wdog_frozen: assert property (state_reg == st_sleep |=> // RQ13
      wdog_reg == $past(wdog_reg))
      else $error("watchdog moved while halted");
   a_zero_flag: assert property (exec && z_upd |=> // RQ14
      z_reg == ($past(res) == 8'h00))
      else $error("zero flag wrong");
endmodule : alu_core

// ---- hw/alu_pkg.sv ----
// constants, register map and enumerations for the accumulator datapath
// Operation
// RQ1 - pointer add sign-extends a 6-bit literal (-32..31) onto the chosen 16-bit pointer, flags untouched.
// RQ2 - the pointer sum wraps modulo 2^16 instead of saturating.
// RQ3 - and_imm_into_acc ands the accumulator with the literal into the accumulator, zero only.
// RQ4 - add_imm_into_acc adds the literal into the accumulator, updating carry, half carry and zero.
// RQ5 - and_acc_with_file ands accumulator and file register to the chosen destination, zero only.
// RQ6 - add_acc_with_file adds accumulator and file register to the chosen destination with all flags.
// RQ7 - arith_shift_right_file keeps bit 7, shifts 7:1 down, old bit 0 to carry, updates carry and zero.
// RQ8 - add_acc_file_carry adds accumulator, file register and carry to the chosen destination with all flags.
// RQ9 - rotate_right_thru_carry rotates the file register right through carry, only carry changes.
// RQ10 - imm_minus_acc stores literal minus accumulator; carry and half carry mean no borrow.
// RQ11 - file_minus_acc stores file minus accumulator to the chosen destination with the same flag sense.
// RQ12 - file_minus_acc_borrow also subtracts the inverted carry, updating all flags.
// RQ13 - sleep clears watchdog counter and prescaler, sets timeout_status_n, clears power_down_status_n, halts.
// RQ14 - carry is the bit 7 carry out, half carry the bit 3 carry out, zero flags an all-zero result.
package alu_pkg;
   localparam int DATA_W = 8;
   localparam int FILE_AW = 7;
   localparam int PTR_W = 16;
   localparam int APB_AW = 8;
   // register byte addresses
   localparam logic [7:0] ADDR_INSTR = 8'h00;
   localparam logic [7:0] ADDR_ACC = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [7:0] ADDR_PTR0 = 8'h0c;
   localparam logic [7:0] ADDR_PTR1 = 8'h10;
   localparam logic [7:0] ADDR_FADDR = 8'h14;
   localparam logic [7:0] ADDR_FDATA = 8'h18;
   localparam logic [7:0] ADDR_WDOG = 8'h1c;
   // instruction word fields
   localparam int OP_LSB = 0;
   localparam int OP_MSB = 3;
   localparam int DEST_BIT = 4;
   localparam int PIDX_BIT = 5;
   localparam int FA_LSB = 8;
   localparam int FA_MSB = 14;
   localparam int LIT_LSB = 16;
   localparam int LIT_MSB = 23;
   // status fields
   localparam int ST_C = 0;
   localparam int ST_DC = 1;
   localparam int ST_Z = 2;
   localparam int ST_PD_N = 3;
   localparam int ST_TO_N = 4;
   localparam int ST_BUSY = 5;
   localparam int ST_HALT = 6;
   localparam int ST_WAKE = 8;
   // reset values
   localparam logic [7:0] ACC_RST = 8'h00;
   localparam logic [15:0] PTR_RST = 16'h0000;
   localparam logic TO_N_RST = 1'b1;
   localparam logic PD_N_RST = 1'b1;
   // watchdog prescaler terminal count
   localparam logic [7:0] WDOG_PRE_MAX = 8'hff;

   typedef enum logic [3:0] {
      pointer_add_imm         = 4'b0000,
      and_imm_into_acc        = 4'b0001,
      add_imm_into_acc        = 4'b0010,
      and_acc_with_file       = 4'b0011,
      add_acc_with_file       = 4'b0100,
      arith_shift_right_file  = 4'b0101,
      add_acc_file_carry      = 4'b0110,
      rotate_right_thru_carry = 4'b0111,
      imm_minus_acc           = 4'b1000,
      file_minus_acc          = 4'b1001,
      file_minus_acc_borrow   = 4'b1010,
      op_sleep                = 4'b1011
   } op_t;

   typedef enum logic [1:0] {
      st_idle  = 2'b00,
      st_fetch = 2'b01,
      st_exec  = 2'b10,
      st_sleep = 2'b11
   } state_t;
endpackage : alu_pkg

// ---- hw/file_mem.sv ----
// file register array with registered read data
module file_mem
   import alu_pkg::*;
(
   // clock
   input  wire logic               clock,
   input  wire logic               rst_n,
   input  wire logic               ce,
   // write port
   input  wire logic               we,
   input  wire logic [FILE_AW-1:0] waddr,
   input  wire logic [DATA_W-1:0]  wdata,
   // read port
   input  wire logic [FILE_AW-1:0] raddr,
   output logic      [DATA_W-1:0]  rdata
);
   logic [DATA_W-1:0] mem [0:(1<<FILE_AW)-1];

   // array itself has no reset, contents are unknown at power-up
   always_ff @(posedge clock) begin
      if (ce && we) begin
         mem[waddr] <= wdata;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         rdata <= '0;
      end else if (ce) begin
         rdata <= mem[raddr];
      end
   end
endmodule : file_mem

// ---- sim/accumulator_alu_instruction_subset_tb.sv ----
// self-checking bench for the accumulator datapath over apb
module accumulator_alu_instruction_subset_tb
   import alu_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   logic        clock;
   logic        rst_n;
   logic        ce;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        halted;
   int          n_mismatch;
   int          n_checks;
   int          cycles;
   logic [31:0] r;
   logic        e;

   alu_core i_dut (
      .clock   (clock),
      .rst_n   (rst_n),
      .ce      (ce),
      .psel    (psel),
      .penable (penable),
      .pwrite  (pwrite),
      .paddr   (paddr),
      .pwdata  (pwdata),
      .prdata  (prdata),
      .pready  (pready),
      .pslverr (pslverr),
      .halted  (halted)
   );

   always #50 clock = ~clock;

   // hang guard, over ten times the expected run length
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         test_done();
      end
   end

   task automatic test_done();
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : test_done

   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_word

   task automatic chk_bit(input logic got, input logic exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_bit

   // request held until pready is seen at a rising edge
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] rd,
                      output logic err);
      @(posedge clock);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] rd;
      logic        err;
      apb(1'b1, a, d, rd, err);
   endtask : wr

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] rd;
      logic        err;
      apb(1'b0, a, 32'h0000_0000, rd, err);
      chk_word(rd, exp);
      chk_bit(err, 1'b0);
   endtask : rd_chk

   // preload acc, file and flags, run one op, read all results back
   task automatic op_case(input logic [3:0] op, input logic d,
                          input logic [6:0] fa, input logic [7:0] lit,
                          input logic [7:0] acc, input logic [7:0] fv,
                          input logic [2:0] fl, input logic [7:0] res,
                          input logic [2:0] efl);
      wr(ADDR_ACC, {24'h000000, acc});
      wr(ADDR_FADDR, {25'h0, fa});
      wr(ADDR_FDATA, {24'h000000, fv});
      wr(ADDR_STATUS, {29'h0, fl});
      wr(ADDR_INSTR, {8'h00, lit, 1'b0, fa, 3'b000, d, op});
      rd_chk(ADDR_ACC, {24'h000000, d ? acc : res});
      rd_chk(ADDR_FDATA, {24'h000000, d ? res : fv});
      rd_chk(ADDR_STATUS, {27'h0, 2'b11, efl});
   endtask : op_case

   task automatic reset_values();
      rd_chk(ADDR_STATUS, 32'h0000_0018);
      rd_chk(ADDR_ACC, 32'h0000_0000);
      rd_chk(ADDR_PTR0, 32'h0000_0000);
      rd_chk(ADDR_PTR1, 32'h0000_0000);
      chk_bit(halted, 1'b0);
   endtask : reset_values

   // both ends of the literal range, both wrap directions, flags kept
   task automatic pointer_wrap();
      wr(ADDR_PTR0, 32'h0000_0005);
      wr(ADDR_PTR1, 32'h0000_fff0);
      wr(ADDR_STATUS, 32'h0000_0007);
      wr(ADDR_INSTR, 32'h0020_0000);
      wr(ADDR_INSTR, 32'h001f_0020);
      rd_chk(ADDR_PTR0, 32'h0000_ffe5);
      rd_chk(ADDR_PTR1, 32'h0000_000f);
      rd_chk(ADDR_STATUS, 32'h0000_001f);
   endtask : pointer_wrap

   task automatic unmapped();
      apb(1'b1, 8'h20, 32'hffff_ffff, r, e);
      chk_bit(e, 1'b1);
      apb(1'b0, 8'h20, 32'h0000_0000, r, e);
      chk_word(r, 32'h0000_0000);
      chk_bit(e, 1'b1);
   endtask : unmapped

   // watchdog has run for several hundred cycles before this
   task automatic sleep_wake();
      wr(ADDR_ACC, 32'h0000_005a);
      wr(ADDR_STATUS, 32'h0000_0002);
      wr(ADDR_INSTR, 32'h0000_000b);
      rd_chk(ADDR_WDOG, 32'h0000_0000);
      rd_chk(ADDR_STATUS, 32'h0000_0052);
      chk_bit(halted, 1'b1);
      repeat (600) @(posedge clock);
      rd_chk(ADDR_WDOG, 32'h0000_0000);
      wr(ADDR_INSTR, 32'h0001_0002);
      rd_chk(ADDR_ACC, 32'h0000_005a);
      wr(ADDR_STATUS, 32'h0000_0102);
      rd_chk(ADDR_STATUS, 32'h0000_0012);
      chk_bit(halted, 1'b0);
      wr(ADDR_INSTR, 32'h0001_0002);
      rd_chk(ADDR_ACC, 32'h0000_005b);
   endtask : sleep_wake

   initial begin
      clock = 1'b0;
      rst_n = 1'b0;
      ce = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      n_mismatch = 0;
      n_checks = 0;
      cycles = 0;
      repeat (12) @(posedge clock);
      rst_n <= 1'b1;
      reset_values();
      pointer_wrap();
      op_case(4'h1, 0, 7'h7f, 8'h0f, 8'hf0, 8'h00, 3'b011, 8'h00, 3'b111);
      op_case(4'h1, 0, 7'h7f, 8'h0f, 8'h3c, 8'h00, 3'b100, 8'h0c, 3'b000);
      op_case(4'h2, 0, 7'h7f, 8'h88, 8'h88, 8'h00, 3'b000, 8'h10, 3'b011);
      op_case(4'h2, 0, 7'h7f, 8'h01, 8'hff, 8'h00, 3'b000, 8'h00, 3'b111);
      op_case(4'h3, 1, 7'h7f, 8'h00, 8'h55, 8'haa, 3'b011, 8'h00, 3'b111);
      op_case(4'h3, 0, 7'h00, 8'h00, 8'h0f, 8'h3c, 3'b100, 8'h0c, 3'b000);
      op_case(4'h4, 1, 7'h7f, 8'h00, 8'h0f, 8'h01, 3'b000, 8'h10, 3'b010);
      op_case(4'h4, 0, 7'h00, 8'h00, 8'h80, 8'h80, 3'b000, 8'h00, 3'b101);
      op_case(4'h5, 0, 7'h7f, 8'h00, 8'h11, 8'h81, 3'b010, 8'hc0, 3'b011);
      op_case(4'h5, 1, 7'h7f, 8'h00, 8'h11, 8'h01, 3'b000, 8'h00, 3'b101);
      op_case(4'h6, 0, 7'h7f, 8'h00, 8'h0f, 8'h00, 3'b001, 8'h10, 3'b010);
      op_case(4'h6, 1, 7'h7f, 8'h00, 8'hff, 8'h00, 3'b001, 8'h00, 3'b111);
      op_case(4'h7, 0, 7'h7f, 8'h00, 8'h22, 8'h01, 3'b101, 8'h80, 3'b101);
      op_case(4'h7, 1, 7'h7f, 8'h00, 8'h22, 8'h80, 3'b011, 8'hc0, 3'b010);
      op_case(4'h8, 0, 7'h7f, 8'h05, 8'h05, 8'h00, 3'b000, 8'h00, 3'b111);
      op_case(4'h8, 0, 7'h7f, 8'h10, 8'h01, 8'h00, 3'b000, 8'h0f, 3'b001);
      op_case(4'h8, 0, 7'h7f, 8'h00, 8'h01, 8'h00, 3'b111, 8'hff, 3'b000);
      op_case(4'h9, 1, 7'h7f, 8'h00, 8'h21, 8'h20, 3'b111, 8'hff, 3'b000);
      op_case(4'h9, 0, 7'h7f, 8'h00, 8'h08, 8'h38, 3'b000, 8'h30, 3'b011);
      op_case(4'ha, 0, 7'h7f, 8'h00, 8'h0f, 8'h10, 3'b000, 8'h00, 3'b101);
      op_case(4'ha, 1, 7'h7f, 8'h00, 8'h0f, 8'h10, 3'b001, 8'h01, 3'b001);
      op_case(4'hc, 0, 7'h7f, 8'h12, 8'h34, 8'h56, 3'b101, 8'h34, 3'b101);
      unmapped();
      sleep_wake();
      test_done();
   end
endmodule : accumulator_alu_instruction_subset_tb
